// ===== design/tcd_cmd_decode.sv
`timescale 1ns/100ps
module tcd_cmd_decode (
  input  wire logic [7:0]       cmd_byte,
  output tcd_pkg::tcd_cmd_e     cmd,
  output logic [4:0]            sel
);

  logic [4:0] num_sel;

  always_comb begin
    num_sel = tcd_pkg::num_to_sel(cmd_byte[2:0]);
    cmd     = tcd_pkg::CMD_NONE;
    sel     = cmd_byte[4:0];
    unique case (cmd_byte[7:5])
      tcd_pkg::OP_ARM:     cmd = tcd_pkg::CMD_ARM;
      tcd_pkg::OP_LOAD:    cmd = tcd_pkg::CMD_LOAD;
      tcd_pkg::OP_LDARM:   cmd = tcd_pkg::CMD_LDARM;
      tcd_pkg::OP_DISARM:  cmd = tcd_pkg::CMD_DISARM;
      tcd_pkg::OP_SAVE:    cmd = tcd_pkg::CMD_SAVE;
      tcd_pkg::OP_DISSAVE: cmd = tcd_pkg::CMD_DISSAVE;
      tcd_pkg::OP_LDPTR: begin
        if (cmd_byte[2:0] != tcd_pkg::GRP_BAD_A && cmd_byte[2:0] != tcd_pkg::GRP_BAD_B) begin
          cmd = tcd_pkg::CMD_LDPTR;
        end
      end
      default: begin
        sel = num_sel;
        if (cmd_byte == tcd_pkg::CODE_MRESET) begin
          cmd = tcd_pkg::CMD_MRST;
        end else if (cmd_byte == tcd_pkg::CODE_SEQ_DIS) begin
          cmd = tcd_pkg::CMD_SEQ_DIS;
        end else if (cmd_byte == tcd_pkg::CODE_SEQ_EN) begin
          cmd = tcd_pkg::CMD_SEQ_EN;
        end else if (cmd_byte == tcd_pkg::CODE_BUS8) begin
          cmd = tcd_pkg::CMD_BUS8;
        end else if (cmd_byte == tcd_pkg::CODE_GATE_OFF) begin
          cmd = tcd_pkg::CMD_GATE_OFF;
        end else if (cmd_byte == tcd_pkg::CODE_GATE_ON) begin
          cmd = tcd_pkg::CMD_GATE_ON;
        end else if (num_sel != '0) begin
          if (cmd_byte[7:3] == tcd_pkg::PFX_SETOUT) begin
            cmd = tcd_pkg::CMD_SETOUT;
          end else if (cmd_byte[7:3] == tcd_pkg::PFX_CLROUT) begin
            cmd = tcd_pkg::CMD_CLROUT;
          end else if (cmd_byte[7:3] == tcd_pkg::PFX_STEP) begin
            cmd = tcd_pkg::CMD_STEP;
          end
        end
      end
    endcase
    if (cmd == tcd_pkg::CMD_NONE) begin
      sel = '0;
    end
  end

endmodule

// ===== design/tcd_counter.sv
`timescale 1ns/100ps
module tcd_counter #(
  parameter int CNT_W = 16
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  input  wire logic             mreset,
  input  wire logic             do_arm,
  input  wire logic             do_load,
  input  wire logic             do_disarm,
  input  wire logic             do_save,
  input  wire logic             do_step,
  input  wire logic             set_out,
  input  wire logic             clr_out,
  input  wire logic             src_edge,
  input  wire logic             gate_lvl,
  input  wire logic             wr_mode,
  input  wire logic             wr_load,
  input  wire logic             wr_hold,
  input  wire logic [CNT_W-1:0] wdata,
  output logic [CNT_W-1:0]      value,
  output logic                  armed,
  output logic                  out_pin
);

  logic [CNT_W-1:0] val_ff, nxt_val, load_ff, nxt_load, hold_ff, nxt_hold, mode_ff, nxt_mode;
  logic             armed_ff, nxt_armed, pend_ff, nxt_pend, tc_ff, nxt_tc;
  logic             tog_ff, nxt_tog, out_ff, nxt_out;
  logic             cnt_go, counted, up;
  logic [2:0]       out_mode;

  always_comb begin
    up       = mode_ff[tcd_pkg::CM_DIR_BIT];
    cnt_go   = (armed_ff || pend_ff) && src_edge &&
               (mode_ff[tcd_pkg::CM_GATE_LSB +: 3] == 3'h0 || gate_lvl);
    counted  = do_load || do_step || cnt_go;
    nxt_val  = val_ff;
    nxt_load = wr_load ? wdata : load_ff;
    nxt_mode = wr_mode ? wdata : mode_ff;
    nxt_hold = wr_hold ? wdata : hold_ff;
    if (do_load) begin
      nxt_val = mode_ff[tcd_pkg::CM_SRC_HOLD_BIT] ? hold_ff : load_ff;
    end else if (do_step || cnt_go) begin
      nxt_val = up ? val_ff + 1'b1 : val_ff - 1'b1;
    end
    if (do_save) begin
      nxt_hold = val_ff;
    end
    nxt_armed = armed_ff;
    nxt_pend  = pend_ff;
    if (do_disarm) begin
      if (tc_ff) begin
        nxt_pend = 1'b1;
      end
      nxt_armed = 1'b0;
    end
    if (pend_ff && counted) begin
      nxt_pend = 1'b0;
    end
    if (do_arm) begin
      nxt_armed = 1'b1;
      nxt_pend  = 1'b0;
    end
    nxt_tc   = up ? (nxt_val == '1) : (nxt_val == '0);
    nxt_tog  = set_out ? 1'b1 : (clr_out ? 1'b0 : tog_ff);
    out_mode = nxt_mode[tcd_pkg::CM_OUT_LSB +: 3];
    if (out_mode == tcd_pkg::OUT_TC_HIGH) begin
      nxt_out = nxt_tc;
    end else if (out_mode == tcd_pkg::OUT_TC_LOW) begin
      nxt_out = !nxt_tc;
    end else begin
      nxt_out = nxt_tog;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || (clk_en && mreset)) begin
      val_ff   <= tcd_pkg::LDHD_RESET;
      load_ff  <= tcd_pkg::LDHD_RESET;
      hold_ff  <= tcd_pkg::LDHD_RESET;
      mode_ff  <= tcd_pkg::CM_RESET;
      armed_ff <= 1'b0;
      pend_ff  <= 1'b0;
      tc_ff    <= 1'b0;
      tog_ff   <= 1'b0;
      out_ff   <= 1'b0;
    end else if (clk_en) begin
      val_ff   <= nxt_val;
      load_ff  <= nxt_load;
      hold_ff  <= nxt_hold;
      mode_ff  <= nxt_mode;
      armed_ff <= nxt_armed;
      pend_ff  <= nxt_pend;
      tc_ff    <= nxt_tc;
      tog_ff   <= nxt_tog;
      out_ff   <= nxt_out;
    end
  end

  assign value   = val_ff;
  assign armed   = armed_ff;
  assign out_pin = out_ff;

endmodule

// ===== design/tcd_pkg.sv
package tcd_pkg;

  localparam int NCNT  = 5;
  localparam int CNT_W = 16;
  localparam int CMD_W = 8;

  // Top three bits of a counter-select command
  localparam logic [2:0] OP_LDPTR   = 3'h0;
  localparam logic [2:0] OP_ARM     = 3'h1;
  localparam logic [2:0] OP_LOAD    = 3'h2;
  localparam logic [2:0] OP_LDARM   = 3'h3;
  localparam logic [2:0] OP_DISSAVE = 3'h4;
  localparam logic [2:0] OP_SAVE    = 3'h5;
  localparam logic [2:0] OP_DISARM  = 3'h6;

  // Five-bit prefixes of single-counter commands
  localparam logic [4:0] PFX_CLROUT = 5'h1c;
  localparam logic [4:0] PFX_SETOUT = 5'h1d;
  localparam logic [4:0] PFX_STEP   = 5'h1e;

  // Whole-byte commands
  localparam logic [7:0] CODE_SEQ_EN   = 8'he0;
  localparam logic [7:0] CODE_BUS8     = 8'he7;
  localparam logic [7:0] CODE_GATE_ON  = 8'he6;
  localparam logic [7:0] CODE_SEQ_DIS  = 8'he8;
  localparam logic [7:0] CODE_GATE_OFF = 8'hee;
  localparam logic [7:0] CODE_MRESET   = 8'hff;

  // Master mode bits
  localparam int MM_DIVIDED_FREQ_OUTPUT_GATE_BIT = 12;
  localparam int MM_BUS_W_BIT     = 13;
  localparam int MM_SEQ_DIS_BIT   = 14;

  // Counter mode fields
  localparam int         CM_OUT_LSB      = 0;
  localparam int         CM_DIR_BIT      = 3;
  localparam int         CM_SRC_HOLD_BIT = 6;
  localparam int         CM_GATE_LSB     = 13;
  localparam logic [2:0] OUT_TC_HIGH     = 3'h1;
  localparam logic [2:0] OUT_TC_LOW      = 3'h5;

  // Reset values
  localparam logic [15:0] MM_RESET   = 16'h0000;
  localparam logic [15:0] CM_RESET   = 16'h0b00;
  localparam logic [15:0] LDHD_RESET = 16'h0000;

  // Data pointer
  localparam logic [1:0] ELEM_MODE     = 2'h0;
  localparam logic [1:0] ELEM_LOAD     = 2'h1;
  localparam logic [1:0] ELEM_HOLD     = 2'h2;
  localparam logic [2:0] GRP_BAD_A     = 3'h0;
  localparam logic [2:0] GRP_BAD_B     = 3'h6;
  localparam logic [2:0] GRP_CTRL      = 3'h7;
  localparam logic [2:0] GRP_FIRST     = 3'h1;
  localparam logic [2:0] GRP_LAST      = 3'h5;
  localparam logic [1:0] ELEM_RESET    = 2'h0;
  localparam logic [2:0] GRP_RESET     = 3'h1;

  typedef enum logic [4:0] {
    CMD_NONE, CMD_ARM, CMD_LOAD, CMD_LDARM, CMD_DISARM, CMD_SAVE, CMD_DISSAVE,
    CMD_SETOUT, CMD_CLROUT, CMD_STEP, CMD_SEQ_DIS, CMD_SEQ_EN, CMD_BUS8,
    CMD_GATE_OFF, CMD_GATE_ON, CMD_LDPTR, CMD_MRST
  } tcd_cmd_e;

  // One-hot counter select from a counter number, zero when out of range
  function automatic logic [NCNT-1:0] num_to_sel(input logic [2:0] num);
    logic [NCNT-1:0] sel;
    sel = '0;
    if (num >= 3'h1 && num <= 3'h5) begin
      sel[num - 3'h1] = 1'b1;
    end
    return sel;
  endfunction

endpackage

// ===== design/tcd_top.sv
// Operation
// - Arm command arms each selected counter; zero select bits change nothing.
// - A counter counts only while armed and its hardware gating allows.
// - Load copies load or hold register per mode; sources stay unchanged.
// - Load-and-arm loads each selected counter and then arms it.
// - Disarm stops counting in each selected counter that is not at terminal count.
// - A counter disarmed at terminal count takes one more count first.
// - Disarmed counters still accept load and save; arm resumes counting.
// - Save copies present count into hold register without disturbing counting.
// - Disarm-and-save disarms then copies count into hold register.
// - Set-output sets the named counter's output toggle, counters one to five.
// - Clear-output resets the named counter's output toggle, counters one to five.
// - Step decrements when direction bit is zero, else increments, even disarmed.
// - Code e8 sets only the pointer sequencing disable bit.
// - Sequencing disable holds the data pointer; otherwise host accesses advance it outside the control group.
// - Code e0 clears only the pointer sequencing disable bit.
// - Code e7 clears bus width bit; data then moves a byte at a time.
// - Code ee sets frequency gate bit; output pin then held low.
// - Code e6 clears frequency gate bit; pin drives the synchronised frequency source.
// - Gate, bus width and sequencing bits also load with full master mode word.
// - Load-pointer copies element and group fields; groups 000 and 110 invalid.
// - Host writes commands to the command port; each byte is decoded.
// - Select bits one to five each address the matching counter independently.
// - Code ff acts as power-on reset of counters and registers.
`timescale 1ns/100ps
module tcd_top #(
  parameter int NCNT  = 5,
  parameter int CNT_W = 16
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              clk_en,
  input  wire logic              cmd_wr_pin,
  input  wire logic [7:0]        cmd_byte_pin,
  input  wire logic              host_acc_pin,
  input  wire logic [CNT_W-1:0]  host_data_pin,
  input  wire logic [NCNT-1:0]   count_src_pin,
  input  wire logic [NCNT-1:0]   gate_pin,
  input  wire logic              freq_src_pin,
  output logic [NCNT-1:0]        counter_output_pin,
  output logic                   divided_freq_output,
  output logic [NCNT-1:0]        armed_status,
  output logic [NCNT*CNT_W-1:0]  count_value,
  output logic [15:0]            master_mode,
  output logic                   byte_pointer,
  output logic [1:0]             element_select_field,
  output logic [2:0]             group_select_field
);

  localparam int SYN_W = 1 + 8 + 1 + CNT_W + NCNT + NCNT + 1;

  // Pin synchronisers
  logic [SYN_W-1:0] syn1_ff;
  logic [SYN_W-1:0] syn2_ff;
  logic             wr_last_ff;
  logic             acc_last_ff;
  logic [NCNT-1:0]  src_last_ff;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      syn1_ff     <= '0;
      syn2_ff     <= '0;
      wr_last_ff  <= 1'b0;
      acc_last_ff <= 1'b0;
      src_last_ff <= '0;
    end else if (clk_en) begin
      syn1_ff     <= {cmd_wr_pin, cmd_byte_pin, host_acc_pin, host_data_pin,
                      count_src_pin, gate_pin, freq_src_pin};
      syn2_ff     <= syn1_ff;
      wr_last_ff  <= syn2_ff[SYN_W-1];
      acc_last_ff <= syn2_ff[SYN_W-10];
      src_last_ff <= syn2_ff[2*NCNT:NCNT+1];
    end
  end

  logic              wr_s, acc_s, freq_s;
  logic [7:0]        byte_s;
  logic [CNT_W-1:0]  data_s;
  logic [NCNT-1:0]   src_s, gate_s, src_edge;
  logic              cmd_go, acc_go;

  always_comb begin
    wr_s     = syn2_ff[SYN_W-1];
    byte_s   = syn2_ff[SYN_W-2 -: 8];
    acc_s    = syn2_ff[SYN_W-10];
    data_s   = syn2_ff[SYN_W-11 -: CNT_W];
    src_s    = syn2_ff[2*NCNT:NCNT+1];
    gate_s   = syn2_ff[NCNT:1];
    freq_s   = syn2_ff[0];
    cmd_go   = wr_s && !wr_last_ff;
    acc_go   = acc_s && !acc_last_ff;
    src_edge = src_s & ~src_last_ff;
  end

  // Command decode
  tcd_pkg::tcd_cmd_e cmd;
  logic [NCNT-1:0]   sel;

  tcd_cmd_decode u_dec (
    .cmd_byte (byte_s),
    .cmd      (cmd),
    .sel      (sel)
  );

  logic [NCNT-1:0] p_arm;
  logic [NCNT-1:0] p_load;
  logic [NCNT-1:0] p_disarm;
  logic [NCNT-1:0] p_save;
  logic [NCNT-1:0] p_step;
  logic [NCNT-1:0] p_set;
  logic [NCNT-1:0] p_clr;
  logic            mreset;

  always_comb begin
    p_arm    = '0;
    p_load   = '0;
    p_disarm = '0;
    p_save   = '0;
    p_step   = '0;
    p_set    = '0;
    p_clr    = '0;
    mreset   = 1'b0;

    if (cmd_go) begin
      unique case (cmd)
        tcd_pkg::CMD_ARM:     p_arm = sel;
        tcd_pkg::CMD_LOAD:    p_load = sel;
        tcd_pkg::CMD_LDARM: begin
          p_load = sel;
          p_arm  = sel;
        end
        tcd_pkg::CMD_DISARM:  p_disarm = sel;
        tcd_pkg::CMD_SAVE:    p_save = sel;
        tcd_pkg::CMD_DISSAVE: begin
          p_disarm = sel;
          p_save   = sel;
        end
        tcd_pkg::CMD_SETOUT:  p_set = sel;
        tcd_pkg::CMD_CLROUT:  p_clr = sel;
        tcd_pkg::CMD_STEP:    p_step = sel;
        tcd_pkg::CMD_MRST:    mreset = 1'b1;
        default: ;
      endcase
    end
  end

  // Data pointer and host data path
  logic [1:0]       elem_ff, nxt_elem;
  logic [2:0]       grp_ff, nxt_grp;
  logic             bptr_ff, nxt_bptr;
  logic [7:0]       low_ff, nxt_low;
  logic [15:0]      mm_ff, nxt_mm;
  logic             commit;
  logic [CNT_W-1:0] commit_data;
  logic [NCNT-1:0]  wr_mode;
  logic [NCNT-1:0]  wr_load;
  logic [NCNT-1:0]  wr_hold;

  always_comb begin
    nxt_elem    = elem_ff;
    nxt_grp     = grp_ff;
    nxt_bptr    = bptr_ff;
    nxt_low     = low_ff;
    commit      = 1'b0;
    commit_data = data_s;

    if (acc_go) begin
      if (!mm_ff[tcd_pkg::MM_BUS_W_BIT]) begin
        nxt_bptr = !bptr_ff;
        if (!bptr_ff) begin
          nxt_low = data_s[7:0];
        end else begin
          commit      = 1'b1;
          commit_data = {data_s[7:0], low_ff};
        end
      end else begin
        commit = 1'b1;
      end
    end

    if (commit && !mm_ff[tcd_pkg::MM_SEQ_DIS_BIT] &&
        grp_ff != tcd_pkg::GRP_CTRL) begin
      if (elem_ff == tcd_pkg::ELEM_HOLD) begin
        nxt_elem = tcd_pkg::ELEM_MODE;
        nxt_grp  = (grp_ff == tcd_pkg::GRP_LAST) ? tcd_pkg::GRP_FIRST
                   : grp_ff + 3'h1;
      end else begin
        nxt_elem = elem_ff + 2'h1;
      end
    end

    if (cmd_go && cmd == tcd_pkg::CMD_LDPTR) begin
      nxt_elem = byte_s[4:3];
      nxt_grp  = byte_s[2:0];
      nxt_bptr = 1'b0;
    end

    if (cmd_go && cmd == tcd_pkg::CMD_MRST) begin
      nxt_elem = tcd_pkg::ELEM_RESET;
      nxt_grp  = tcd_pkg::GRP_RESET;
      nxt_bptr = 1'b0;
    end
  end

  always_comb begin
    wr_mode = '0;
    wr_load = '0;
    wr_hold = '0;
    for (int i = 0; i < NCNT; i++) begin
      if (commit && grp_ff == 3'(i + 1)) begin
        wr_mode[i] = (elem_ff == tcd_pkg::ELEM_MODE);
        wr_load[i] = (elem_ff == tcd_pkg::ELEM_LOAD);
        wr_hold[i] = (elem_ff == tcd_pkg::ELEM_HOLD);
      end
    end
  end

  // Master mode register
  always_comb begin
    nxt_mm = mm_ff;
    if (commit && grp_ff == tcd_pkg::GRP_CTRL &&
        elem_ff == tcd_pkg::ELEM_MODE) begin
      nxt_mm = commit_data;
    end

    if (cmd_go) begin
      unique case (cmd)
        tcd_pkg::CMD_SEQ_DIS:  nxt_mm[tcd_pkg::MM_SEQ_DIS_BIT] = 1'b1;
        tcd_pkg::CMD_SEQ_EN:   nxt_mm[tcd_pkg::MM_SEQ_DIS_BIT] = 1'b0;
        tcd_pkg::CMD_BUS8:     nxt_mm[tcd_pkg::MM_BUS_W_BIT] = 1'b0;
        tcd_pkg::CMD_GATE_OFF: nxt_mm[tcd_pkg::MM_DIVIDED_FREQ_OUTPUT_GATE_BIT] = 1'b1;
        tcd_pkg::CMD_GATE_ON:  nxt_mm[tcd_pkg::MM_DIVIDED_FREQ_OUTPUT_GATE_BIT] = 1'b0;
        tcd_pkg::CMD_MRST:     nxt_mm = tcd_pkg::MM_RESET;
        default: ;
      endcase
    end
  end

  logic divided_freq_output_ff;
  logic nxt_divided_freq_output;

  always_comb begin
    nxt_divided_freq_output = nxt_mm[tcd_pkg::MM_DIVIDED_FREQ_OUTPUT_GATE_BIT] ? 1'b0 : freq_s;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      elem_ff <= tcd_pkg::ELEM_RESET;
      grp_ff  <= tcd_pkg::GRP_RESET;
      bptr_ff <= 1'b0;
      low_ff  <= 8'h00;
      mm_ff   <= tcd_pkg::MM_RESET;
      divided_freq_output_ff <= 1'b0;
    end else if (clk_en) begin
      elem_ff <= nxt_elem;
      grp_ff  <= nxt_grp;
      bptr_ff <= nxt_bptr;
      low_ff  <= nxt_low;
      mm_ff   <= nxt_mm;
      divided_freq_output_ff <= nxt_divided_freq_output;
    end
  end

  // General counters
  for (genvar g = 0; g < NCNT; g++) begin : g_cnt
    tcd_counter #(
      .CNT_W (CNT_W)
    ) u_cnt (
      .core_clk  (core_clk),
      .rst       (rst),
      .clk_en    (clk_en),
      .mreset    (mreset),
      .do_arm    (p_arm[g]),
      .do_load   (p_load[g]),
      .do_disarm (p_disarm[g]),
      .do_save   (p_save[g]),
      .do_step   (p_step[g]),
      .set_out   (p_set[g]),
      .clr_out   (p_clr[g]),
      .src_edge  (src_edge[g]),
      .gate_lvl  (gate_s[g]),
      .wr_mode   (wr_mode[g]),
      .wr_load   (wr_load[g]),
      .wr_hold   (wr_hold[g]),
      .wdata     (commit_data),
      .value     (count_value[g*CNT_W +: CNT_W]),
      .armed     (armed_status[g]),
      .out_pin   (counter_output_pin[g])
    );
  end

  assign divided_freq_output  = divided_freq_output_ff;
  assign master_mode          = mm_ff;
  assign byte_pointer         = bptr_ff;
  assign element_select_field = elem_ff;
  assign group_select_field   = grp_ff;

endmodule

// ===== testbench/tcd_host_model.sv
`timescale 1ns/100ps
module tcd_host_model (
  input  wire logic  core_clk,
  output logic       cmd_wr_pin,
  output logic [7:0] cmd_byte_pin,
  output logic       host_acc_pin,
  output logic [15:0] host_data_pin
);
  initial begin
    cmd_wr_pin = 1'b0;
    host_acc_pin = 1'b0;
    cmd_byte_pin = 8'h00;
    host_data_pin = 16'h0000;
  end
  // Strobe high 3 cycles, low 3; lines turn over once hold time ends
  task automatic cmd(input logic [7:0] c);
    @(posedge core_clk);
    #1;
    cmd_byte_pin = c;
    cmd_wr_pin = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    cmd_wr_pin = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    cmd_byte_pin = ~c;
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge core_clk);
    #1;
    host_data_pin = {~d, d};
    host_acc_pin = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    host_acc_pin = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    host_data_pin = ~host_data_pin;
  endtask
endmodule

// ===== testbench/tcd_top_monitor.sv
`timescale 1ns/100ps
module tcd_top_monitor #(
  parameter int NCNT  = 5,
  parameter int CNT_W = 16
) (
  input wire logic                  core_clk,
  input wire logic                  rst,
  input wire logic                  clk_en,
  input wire logic                  cmd_wr_pin,
  input wire logic [7:0]            cmd_byte_pin,
  input wire logic [NCNT-1:0]       counter_output_pin,
  input wire logic                  divided_freq_output,
  input wire logic [NCNT-1:0]       armed_status,
  input wire logic [NCNT*CNT_W-1:0] count_value,
  input wire logic [15:0]           master_mode,
  input wire logic [1:0]            element_select_field,
  input wire logic [2:0]            group_select_field
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [7:0] b;
  logic [2:0] n;
  logic       bad;
  assign b = cmd_byte_pin;
  assign n = b[2:0] - 3'h1;
  assign bad = (b inside {8'hef, 8'hf0, 8'hf6, 8'hf7}) ||
               (b[7:5] == 3'h0 && (b[2:0] == 3'h0 || b[2:0] == 3'h6));
  // Strobe seen, applied two edges on, result checked one edge later
  sequence s_cmd;
    ($rose(cmd_wr_pin) && clk_en) ##1 clk_en [*2] ##1 1'b1;
  endsequence
  sequence s_op(logic [2:0] op);
    s_cmd ##0 (b[7:5] == op);
  endsequence
  a_arm_sets: assert property (s_op(3'h1) |-> armed_status == ($past(armed_status) | b[4:0]))
    else $error("arm result wrong");
  a_ldarm_sets: assert property (s_op(3'h3) |-> armed_status == ($past(armed_status) | b[4:0]))
    else $error("load and arm result wrong");
  a_disarm_clears: assert property (s_op(3'h6) |-> armed_status == ($past(armed_status) & ~b[4:0]))
    else $error("disarm result wrong");
  a_dissave_clears: assert property (s_op(3'h4) |-> armed_status == ($past(armed_status) & ~b[4:0]))
    else $error("disarm and save result wrong");
  a_seq_bit: assert property (s_cmd ##0 (b == 8'he8 || b == 8'he0) |->
    master_mode == (($past(master_mode) & 16'hbfff) | {1'b0, b[3], 14'h0}))
    else $error("sequencing bit wrong");
  a_gate_bit: assert property (s_cmd ##0 (b == 8'hee || b == 8'he6) |->
    master_mode == (($past(master_mode) & 16'hefff) | {3'h0, b[3], 12'h0}))
    else $error("gate bit wrong");
  a_bus_narrow: assert property (s_cmd ##0 (b == 8'he7) |->
    master_mode == ($past(master_mode) & 16'hdfff))
    else $error("bus width bit wrong");
  a_divided_freq_output_held: assert property (master_mode[12] |-> divided_freq_output == 1'b0)
    else $error("frequency output not held low");
  a_out_set: assert property (s_cmd ##0 (b[7:3] == 5'h1d && n < 3'h5) |-> counter_output_pin[n])
    else $error("output not set");
  a_out_clr: assert property (s_cmd ##0 (b[7:3] == 5'h1c && n < 3'h5) |-> !counter_output_pin[n])
    else $error("output not cleared");
  a_ptr_load: assert property (s_op(3'h0) ##0 !bad |->
    element_select_field == b[4:3] && group_select_field == b[2:0])
    else $error("pointer load wrong");
  a_undef_ignored: assert property (s_cmd ##0 bad |-> $stable(armed_status) && $stable(master_mode)
    && $stable(count_value) && $stable(group_select_field) && $stable(counter_output_pin))
    else $error("undefined byte changed state");
  a_mreset_all: assert property (s_cmd ##0 (b == 8'hff) |-> armed_status == '0 && master_mode == '0
    && count_value == '0 && element_select_field == 2'h0 && group_select_field == 3'h1)
    else $error("master reset incomplete");
endmodule
bind tcd_top tcd_top_monitor #(.NCNT(NCNT), .CNT_W(CNT_W)) u_mon (
  .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .cmd_wr_pin(cmd_wr_pin),
  .cmd_byte_pin(cmd_byte_pin), .counter_output_pin(counter_output_pin),
  .divided_freq_output(divided_freq_output), .armed_status(armed_status),
  .count_value(count_value), .master_mode(master_mode),
  .element_select_field(element_select_field), .group_select_field(group_select_field));

// ===== testbench/tcd_top_tb.sv
`timescale 1ns/100ps
module tcd_top_tb;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        clk_en = 1'b1;
  logic        cmd_wr_pin, host_acc_pin, divided_freq_output, byte_pointer;
  logic        freq_src_pin = 1'b0;
  logic [7:0]  cmd_byte_pin;
  logic [15:0] host_data_pin, master_mode;
  logic [4:0]  count_src_pin = 5'h00;
  logic [4:0]  gate_pin = 5'h00;
  logic [4:0]  counter_output_pin, armed_status;
  logic [79:0] count_value;
  logic [1:0]  element_select_field;
  logic [2:0]  group_select_field;
  int          n_errors = 0;
  int          samples_checked = 0;
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) freq_src_pin <= #1 ~freq_src_pin;
  tcd_host_model host (.core_clk(core_clk), .cmd_wr_pin(cmd_wr_pin), .cmd_byte_pin(cmd_byte_pin),
    .host_acc_pin(host_acc_pin), .host_data_pin(host_data_pin));
  tcd_top dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .cmd_wr_pin(cmd_wr_pin),
    .cmd_byte_pin(cmd_byte_pin), .host_acc_pin(host_acc_pin), .host_data_pin(host_data_pin),
    .count_src_pin(count_src_pin), .gate_pin(gate_pin), .freq_src_pin(freq_src_pin),
    .counter_output_pin(counter_output_pin), .divided_freq_output(divided_freq_output),
    .armed_status(armed_status), .count_value(count_value), .master_mode(master_mode),
    .byte_pointer(byte_pointer), .element_select_field(element_select_field),
    .group_select_field(group_select_field));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [15:0] cnt(input int i);
    return count_value[16*i +: 16];
  endfunction
  task automatic pulse(input int i);
    count_src_pin[i] = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    count_src_pin[i] = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  task automatic t_out;
    for (int n = 1; n <= 5; n++) begin
      host.cmd(8'he8 | 8'(n));
      check("out set", 16'(counter_output_pin), 16'(5'h01 << (n - 1)));
      host.cmd(8'he0 | 8'(n));
      check("out clr", 16'(counter_output_pin), 16'h0000);
    end
    $display("t_out done");
  endtask
  task automatic t_arm;
    host.cmd(8'h35);
    check("armed", 16'(armed_status), 16'h0015);
    host.cmd(8'h22);
    check("armed", 16'(armed_status), 16'h0017);
    host.cmd(8'hd4);
    check("armed", 16'(armed_status), 16'h0003);
    host.cmd(8'h83);
    check("armed", 16'(armed_status), 16'h0000);
    $display("t_arm done");
  endtask
  task automatic t_count;
    host.cmd(8'h21);
    pulse(0);
    check("cnt1", cnt(0), 16'hffff);
    host.cmd(8'hc1);
    pulse(0);
    check("cnt1", cnt(0), 16'hffff);
    host.cmd(8'h41);
    check("cnt1", cnt(0), 16'h0000);
    host.cmd(8'h21);
    host.cmd(8'hc1);
    check("armed", 16'(armed_status), 16'h0000);
    pulse(0);
    check("cnt1", cnt(0), 16'hffff);
    pulse(0);
    check("cnt1", cnt(0), 16'hffff);
    host.cmd(8'h61);
    check("cnt1", cnt(0), 16'h0000);
    check("armed", 16'(armed_status), 16'h0001);
    $display("t_count done");
  endtask
  task automatic t_data;
    host.cmd(8'h0a);
    check("ptr", {11'h0, element_select_field, group_select_field}, 16'h000a);
    host.wr(8'h34);
    check("bytep", 16'(byte_pointer), 16'h0001);
    host.wr(8'h12);
    check("ptr", {11'h0, element_select_field, group_select_field}, 16'h0012);
    host.cmd(8'h42);
    check("cnt2", cnt(1), 16'h1234);
    host.cmd(8'hf2);
    check("cnt2", cnt(1), 16'h1233);
    host.cmd(8'ha2);
    check("cnt2", cnt(1), 16'h1233);
    host.cmd(8'h42);
    check("cnt2", cnt(1), 16'h1234);
    host.cmd(8'h03);
    host.cmd(8'he8);
    host.wr(8'h08);
    host.wr(8'h00);
    check("ptr", {11'h0, element_select_field, group_select_field}, 16'h0003);
    host.cmd(8'he0);
    host.cmd(8'hf3);
    check("cnt3", cnt(2), 16'h0001);
    $display("t_data done");
  endtask
  task automatic t_mm;
    logic f0;
    host.cmd(8'he8);
    check("mm", master_mode, 16'h4000);
    host.cmd(8'hee);
    check("mm", master_mode, 16'h5000);
    repeat (5) @(posedge core_clk);
    check("divided_freq_output", 16'(divided_freq_output), 16'h0000);
    host.cmd(8'he6);
    check("mm", master_mode, 16'h4000);
    repeat (2) begin
      @(posedge core_clk);
      f0 = freq_src_pin;
      repeat (2) @(posedge core_clk);
      #1;
      check("divided_freq_output", 16'(divided_freq_output), 16'(f0));
    end
    host.cmd(8'he0);
    check("mm", master_mode, 16'h0000);
    host.cmd(8'h07);
    host.wr(8'h00);
    host.wr(8'h30);
    check("mm", master_mode, 16'h3000);
    host.cmd(8'he7);
    check("mm", master_mode, 16'h1000);
    host.cmd(8'he6);
    $display("t_mm done");
  endtask
  task automatic t_bad;
    logic [7:0] codes[6] = '{8'hef, 8'hf0, 8'hf6, 8'hf7, 8'h10, 8'h16};
    host.cmd(8'h0b);
    foreach (codes[i]) begin
      host.cmd(codes[i]);
      check("armed", 16'(armed_status), 16'h0001);
      check("mm", master_mode, 16'h0000);
      check("ptr", {11'h0, element_select_field, group_select_field}, 16'h000b);
      check("cnt2", cnt(1), 16'h1234);
    end
    $display("t_bad done");
  endtask
  task automatic t_gate;
    host.cmd(8'h04);
    host.wr(8'h00);
    host.wr(8'h20);
    host.cmd(8'h28);
    pulse(3);
    check("cnt4", cnt(3), 16'h0000);
    gate_pin[3] = 1'b1;
    pulse(3);
    check("cnt4", cnt(3), 16'hffff);
    clk_en = 1'b0;
    host.cmd(8'hc8);
    clk_en = 1'b1;
    check("armed", 16'(armed_status), 16'h0009);
    $display("t_gate done");
  endtask
  task automatic t_mrst;
    host.cmd(8'hff);
    check("armed", 16'(armed_status), 16'h0000);
    check("cnt2", cnt(1), 16'h0000);
    check("ptr", {11'h0, element_select_field, group_select_field}, 16'h0001);
    $display("t_mrst done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    #1;
    rst = 1'b0;
    t_out();
    t_arm();
    t_count();
    t_data();
    t_mm();
    t_bad();
    t_gate();
    t_mrst();
    final_report();
  end
endmodule
